// ### logic/sfar_params.svh
// Constants of the serial flash array read front end.
`ifndef SFAR_PARAMS_SVH
`define SFAR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------------
`define SFAR_CMD_PLAIN        8'h03
`define SFAR_CMD_PLAIN_WIDE   8'h13
`define SFAR_CMD_FAST         8'h0b
`define SFAR_CMD_FAST_WIDE    8'h0c
`define SFAR_CMD_TWO_OUT      8'h3b
`define SFAR_CMD_TWO_OUT_WIDE 8'h3c
`define SFAR_CMD_FOUR_OUT     8'h6b
`define SFAR_CMD_FOUR_OUT_W   8'h6c
`define SFAR_CMD_TWO_IO       8'hbb
`define SFAR_CMD_TWO_IO_WIDE  8'hbc

// ----------------------------------------------------------------------------
// Frame layout and pin codes
// ----------------------------------------------------------------------------
`define SFAR_CMD_LAST     6'd7
`define SFAR_ADDR_NARROW  6'd24
`define SFAR_ADDR_WIDE    6'd32
`define SFAR_MODE_LAST    6'd6
`define SFAR_MODE_CONT    4'ha
`define SFAR_BYTE_BITS    4'd8
`define SFAR_OE_OFF       4'hf
`define SFAR_OE_ONE       4'hd
`define SFAR_OE_TWO       4'hc
`define SFAR_OE_FOUR      4'h0
`define SFAR_ARRAY_ADDR_W 24
// Synchroniser reset: chip select high, clock low, as on an idle mode-0 link.
`define SFAR_PIN_IDLE     6'h20
`define SFAR_FIFO_DEPTH   16

`endif

// ### logic/sfar_pkg.sv
// Types shared by the serial flash array read front end.
`default_nettype none
package sfar_pkg;

  // --------------------------------------------------------------------------
  // Frame phases, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_CMD    = 7'b0000010,
    ST_ADDR   = 7'b0000100,
    ST_MODE   = 7'b0001000,
    ST_DUMMY  = 7'b0010000,
    ST_DATA   = 7'b0100000,
    ST_IGNORE = 7'b1000000
  } sfar_state_t;

  typedef enum logic [1:0] {
    LANE_ONE  = 2'b00,
    LANE_TWO  = 2'b01,
    LANE_FOUR = 2'b10
  } sfar_lane_t;

  // Decoded read command.
  typedef struct packed {
    logic       valid;
    logic       wide;
    logic       dual_in;
    sfar_lane_t lanes;
    logic       lat0;
    logic       lat3;
  } sfar_cfg_t;

endpackage : sfar_pkg

`default_nettype wire

// ### logic/sfar_fifo.sv
// Byte prefetch FIFO between the array port and the output shifter.
`timescale 1ns/10ps
`default_nettype none

module sfar_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         flush,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_reg [D];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          push, pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(D - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready  = (cnt_reg != CW'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_ready && out_valid && !flush;

  // ---------------------------------------------------------------------------
  // Pointers; a flush drops everything, including a word arriving with it.
  // ---------------------------------------------------------------------------
  always_comb begin
    wr_next  = push ? bump(wr_reg) : wr_reg;
    rd_next  = pop ? bump(rd_reg) : rd_reg;
    cnt_next = cnt_reg + CW'(push) - CW'(pop);
    if (flush) begin
      wr_next  = '0;
      rd_next  = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; it is only read below the fill count.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

endmodule : sfar_fifo

`default_nettype wire

// ### logic/sfar_core.sv
// Array read front end of a serial NOR flash, sampled on the system clock.
`timescale 1ns/10ps
`default_nettype none
`include "sfar_params.svh"

// Summary of operation
// RULE1 - Plain read: 3-byte address, or 4-byte if address length set; 13h always 4.
// RULE2 - Plain read returns data on the single output line, no dummy cycles.
// RULE3 - Reads start at any byte; address advances after every byte.
// RULE4 - After the top array byte the address wraps to zero and continues.
// RULE5 - Fast read uses the same address length choice; 0Ch always 4 bytes.
// RULE6 - Fast read inserts latency-two dummy cycles; data line ignored meanwhile.
// RULE7 - Host keeps the clock at or below 133 MHz for fast reads.
// RULE8 - Two-line output read: 3 or 4 byte address; 3Ch always 4.
// RULE9 - Two-line reads drive two bits per clock on IO1/IO0 at falling edges.
// RULE10 - Two and four line output reads insert latency-three dummy cycles.
// RULE11 - Four-line output read: 3 or 4 byte address; 6Ch always 4.
// RULE12 - Four-line read drives one nibble per clock at falling edges.
// RULE13 - Two-line address read: 3 or 4 byte address, two bits per clock.
// RULE14 - Host keeps the clock at or below 133 MHz for two-line address reads.
// RULE15 - Frame: instruction, address, four mode clocks, latency-two dummies, data.
// RULE16 - Mode upper nibble A keeps continuous mode; next frame starts at address.
// RULE17 - Any other mode value leaves continuous mode at chip select rise.
// RULE18 - A mode reset frame also leaves continuous mode.
// RULE19 - Only the mode upper nibble matters; lower nibble ignored.
// RULE20 - Host releases IO lines before the first data falling edge.
// RULE21 - Host should not end a frame inside mode or dummy cycles.
// RULE22 - Address top bit is 23 in 3-byte mode, 31 in 4-byte mode.
// RULE23 - Chip select high ends a read at any point of the data phase.
// RULE24 - Address bits above 23 are ignored.
// RULE25 - Instruction bits on rising edges; dummies counted falling to falling.
// RULE26 - Outputs stay released with chip select high and before data.
// RULE27 - Bytes leave most significant first; address taken most significant first.
module sfar_core
  import sfar_pkg::*;
#(
  parameter int ADDR_W = `SFAR_ARRAY_ADDR_W,
  parameter int FIFO_D = `SFAR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Serial link pins
  input  wire logic              spi_sck,
  input  wire logic              spi_cs_n,
  input  wire logic [3:0]        io_in,
  output logic      [3:0]        io_out,
  output logic      [3:0]        io_oe_n,
  // Configuration
  input  wire logic              volatile_config_two_addr_wide,
  input  wire logic [3:0]        volatile_config_two_latency,
  input  wire logic [3:0]        volatile_config_three_latency,
  // Status
  output logic                   execute_in_place_active,
  // Array port
  output logic      [ADDR_W-1:0] arr_addr,
  output logic                   arr_rd,
  input  wire logic [7:0]        arr_rdata
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [5:0] meta_reg, sync_reg;
  logic       sck_d_reg, cs_d_reg;
  logic       sck_s, cs_s, rise, fall;

  // Two flops on every pin; only the second stage feeds logic.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      meta_reg  <= `SFAR_PIN_IDLE;
      sync_reg  <= `SFAR_PIN_IDLE;
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
    end else begin
      meta_reg  <= {spi_cs_n, spi_sck, io_in};
      sync_reg  <= meta_reg;
      sck_d_reg <= sck_s;
      cs_d_reg  <= cs_s;
    end
  end

  assign sck_s = sync_reg[4];
  assign cs_s  = sync_reg[5];
  assign rise  = sck_s && !sck_d_reg && !cs_s;
  assign fall  = !sck_s && sck_d_reg && !cs_s;

  // ---------------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------------
  function automatic sfar_cfg_t decode(input logic [7:0] c);
    sfar_cfg_t r;
    r       = '0;
    r.valid = 1'b1;
    case (c)
      `SFAR_CMD_PLAIN:        r.lat0 = 1'b1; // RULE1 RULE2
      `SFAR_CMD_PLAIN_WIDE: begin
        r.lat0 = 1'b1;
        r.wide = 1'b1; // RULE1
      end
      `SFAR_CMD_FAST:         r.wide = 1'b0;
      `SFAR_CMD_FAST_WIDE:    r.wide = 1'b1; // RULE5
      `SFAR_CMD_TWO_OUT, `SFAR_CMD_TWO_OUT_WIDE: begin
        r.lanes = LANE_TWO;
        r.lat3  = 1'b1; // RULE10
        r.wide  = c[2]; // RULE8
      end
      `SFAR_CMD_FOUR_OUT, `SFAR_CMD_FOUR_OUT_W: begin
        r.lanes = LANE_FOUR;
        r.lat3  = 1'b1; // RULE10
        r.wide  = c[2]; // RULE11
      end
      `SFAR_CMD_TWO_IO, `SFAR_CMD_TWO_IO_WIDE: begin
        r.lanes   = LANE_TWO;
        r.dual_in = 1'b1; // RULE13
        r.wide    = c[2];
      end
      default:                r.valid = 1'b0;
    endcase
    return r;
  endfunction : decode

  // ---------------------------------------------------------------------------
  // Frame sequencer, output shifter and array fetch
  // ---------------------------------------------------------------------------
  sfar_state_t       state_reg, state_next;
  sfar_cfg_t         cfg_reg, cfg_next, dec;
  logic [31:0]       sh_reg, sh_next, sh_in;
  logic [5:0]        cnt_reg, cnt_next, in_w, lat;
  logic              cont_reg, cont_next, mode_ok_reg, mode_ok_next;
  logic [7:0]        dout_reg, dout_next, byte_v;
  logic [3:0]        left_reg, left_next, lft;
  logic [3:0]        io_out_reg, io_out_next, oe_n_reg, oe_n_next;
  logic              fetch_en_reg, fetch_en_next, rd_pend_reg, arr_rd_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              flush, pop, launch, fifo_in_ready, fifo_out_valid;
  logic [7:0]        fifo_out_data;
  logic              dual_now;

  assign dual_now = ((state_reg == ST_ADDR) || (state_reg == ST_MODE)) && cfg_reg.dual_in;
  assign in_w     = dual_now ? 6'd2 : 6'd1;
  assign sh_in    = dual_now ? {sh_reg[29:0], sync_reg[1:0]} : {sh_reg[30:0], sync_reg[0]};
  assign dec      = decode(sh_in[7:0]);
  assign lat      = cfg_reg.lat0 ? 6'd0 :
                    {2'b00, cfg_reg.lat3 ? volatile_config_three_latency
                                         : volatile_config_two_latency}; // RULE6 RULE10

  always_comb begin
    state_next    = state_reg;
    cfg_next      = cfg_reg;
    sh_next       = sh_reg;
    cnt_next      = cnt_reg;
    cont_next     = cont_reg;
    mode_ok_next  = mode_ok_reg;
    dout_next     = dout_reg;
    left_next     = left_reg;
    io_out_next   = io_out_reg;
    oe_n_next     = oe_n_reg;
    fetch_en_next = fetch_en_reg;
    addr_next     = addr_reg;
    flush         = 1'b0;
    pop           = 1'b0;
    launch        = 1'b0;
    byte_v        = dout_reg;
    lft           = left_reg;
    // One fetch in flight at most, so a FIFO slot is always free for it.
    arr_rd_next   = fetch_en_reg && !arr_rd && !rd_pend_reg && fifo_in_ready;
    if (arr_rd) begin
      addr_next = addr_reg + 1'b1; // RULE3 RULE4
    end
    if (cs_s) begin
      // Frame over: release the lines and stop prefetching.
      state_next    = ST_IDLE; // RULE23
      oe_n_next     = `SFAR_OE_OFF; // RULE26
      fetch_en_next = 1'b0;
      if (!cs_d_reg) begin
        cont_next    = mode_ok_reg; // RULE16 RULE17 RULE18
        mode_ok_next = 1'b0;
      end
    end else if (state_reg == ST_IDLE) begin
      // A continuous frame skips the instruction byte.
      state_next = cont_reg ? ST_ADDR : ST_CMD; // RULE16
      cnt_next   = '0;
    end else if (rise) begin
      case (state_reg)
        ST_CMD: begin
          sh_next  = sh_in; // RULE25
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == `SFAR_CMD_LAST) begin
            cfg_next      = dec;
            cfg_next.wide = dec.wide || volatile_config_two_addr_wide; // RULE1 RULE5 RULE8 RULE11 RULE13
            state_next    = dec.valid ? ST_ADDR : ST_IGNORE;
            cnt_next      = '0;
          end
        end
        ST_ADDR: begin
          sh_next  = sh_in; // RULE27
          cnt_next = cnt_reg + in_w;
          if ((cnt_reg + in_w) == (cfg_reg.wide ? `SFAR_ADDR_WIDE : `SFAR_ADDR_NARROW)) begin
            // High address bits simply fall off the array width.
            addr_next     = sh_in[ADDR_W-1:0]; // RULE22 RULE24
            flush         = 1'b1;
            fetch_en_next = 1'b1;
            arr_rd_next   = 1'b0;
            left_next     = '0;
            cnt_next      = '0;
            state_next    = cfg_reg.dual_in ? ST_MODE : ST_DUMMY; // RULE15
          end
        end
        ST_MODE: begin
          sh_next  = sh_in;
          cnt_next = cnt_reg + in_w;
          if (cnt_reg == `SFAR_MODE_LAST) begin
            mode_ok_next = (sh_in[7:4] == `SFAR_MODE_CONT); // RULE19
            cnt_next     = '0;
            state_next   = ST_DUMMY;
          end
        end
        default: cnt_next = cnt_reg;
      endcase
    end else if (fall) begin
      case (state_reg)
        ST_DUMMY: begin
          // The falling edge after the last dummy already carries data.
          if (cnt_reg == lat) begin // RULE25
            state_next = ST_DATA;
            launch     = 1'b1;
          end else begin
            cnt_next = cnt_reg + 1'b1; // RULE6
          end
        end
        ST_DATA: launch = 1'b1; // RULE9 RULE12
        default: cnt_next = cnt_reg;
      endcase
    end
    if (launch) begin
      if (left_reg == '0) begin
        byte_v = fifo_out_data;
        pop    = 1'b1;
        lft    = `SFAR_BYTE_BITS;
      end
      // Most significant bits leave first on every lane width.
      case (cfg_reg.lanes)
        LANE_TWO: begin
          io_out_next = {2'b00, byte_v[7:6]}; // RULE9 RULE27
          oe_n_next   = `SFAR_OE_TWO;
          dout_next   = {byte_v[5:0], 2'b00};
          left_next   = lft - 4'd2;
        end
        LANE_FOUR: begin
          io_out_next = byte_v[7:4]; // RULE12
          oe_n_next   = `SFAR_OE_FOUR;
          dout_next   = {byte_v[3:0], 4'h0};
          left_next   = lft - 4'd4;
        end
        default: begin
          io_out_next = {2'b00, byte_v[7], 1'b0}; // RULE2
          oe_n_next   = `SFAR_OE_ONE;
          dout_next   = {byte_v[6:0], 1'b0};
          left_next   = lft - 4'd1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg    <= ST_IDLE;
      cfg_reg      <= '0;
      sh_reg       <= '0;
      cnt_reg      <= '0;
      cont_reg     <= 1'b0;
      mode_ok_reg  <= 1'b0;
      dout_reg     <= '0;
      left_reg     <= '0;
      io_out_reg   <= '0;
      oe_n_reg     <= `SFAR_OE_OFF;
      fetch_en_reg <= 1'b0;
      addr_reg     <= '0;
      arr_rd       <= 1'b0;
      rd_pend_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cfg_reg      <= cfg_next;
      sh_reg       <= sh_next;
      cnt_reg      <= cnt_next;
      cont_reg     <= cont_next;
      mode_ok_reg  <= mode_ok_next;
      dout_reg     <= dout_next;
      left_reg     <= left_next;
      io_out_reg   <= io_out_next;
      oe_n_reg     <= oe_n_next;
      fetch_en_reg <= fetch_en_next;
      addr_reg     <= addr_next;
      arr_rd       <= arr_rd_next;
      rd_pend_reg  <= arr_rd && !flush;
    end
  end

  assign io_out                  = io_out_reg;
  assign io_oe_n                 = oe_n_reg;
  assign arr_addr                = addr_reg;
  assign execute_in_place_active = cont_reg;

  // ---------------------------------------------------------------------------
  // Prefetch buffer; a full buffer holds back the array reads.
  // ---------------------------------------------------------------------------
  sfar_fifo #(
    .W (8),
    .D (FIFO_D)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .flush     (flush),
    .in_valid  (rd_pend_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (arr_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_RELEASE_OUTSIDE_DATA: assert property ( // RULE26
    (state_reg != ST_DATA) |-> (io_oe_n == `SFAR_OE_OFF))
    else $error("IO driven outside the data phase");
  AST_CS_ENDS_READ: assert property ( // RULE23
    cs_s && (state_reg == ST_DATA) |=> (state_reg == ST_IDLE) && (io_oe_n == `SFAR_OE_OFF))
    else $error("Read did not end on chip select rise");
  AST_ADDR_ADVANCE: assert property ( // RULE3
    arr_rd && !flush |=> (arr_addr == $past(arr_addr) + 1'b1))
    else $error("Array address did not advance");
  AST_ADDR_WRAP: assert property ( // RULE4
    arr_rd && (&arr_addr) && !flush |=> (arr_addr == '0))
    else $error("Array address did not wrap to zero");
  AST_ONE_LANE: assert property ( // RULE2
    (state_reg == ST_DATA) && (cfg_reg.lanes == LANE_ONE) && !cs_s
      |-> (io_oe_n == `SFAR_OE_ONE))
    else $error("Single read not on the one output line");
  AST_TWO_LANE: assert property ( // RULE9
    (state_reg == ST_DATA) && (cfg_reg.lanes == LANE_TWO) && !cs_s
      |-> (io_oe_n == `SFAR_OE_TWO))
    else $error("Two-line read not on IO1 and IO0");
  AST_FOUR_LANE: assert property ( // RULE12
    (state_reg == ST_DATA) && (cfg_reg.lanes == LANE_FOUR) && !cs_s
      |-> (io_oe_n == `SFAR_OE_FOUR))
    else $error("Four-line read not on all lines");
  AST_DATA_ON_FALL: assert property ( // RULE9
    $changed(io_out) |-> $past(fall))
    else $error("Data changed away from a falling edge");
  AST_CONT_KEEP: assert property ( // RULE16
    cs_s && !cs_d_reg && mode_ok_reg |=> cont_reg ##1 cont_reg)
    else $error("Continuous mode not kept");
  AST_CONT_LEAVE: assert property ( // RULE17
    cs_s && !cs_d_reg && !mode_ok_reg |=> !cont_reg)
    else $error("Continuous mode not left");
  AST_DUMMY_LEN: assert property ( // RULE6
    (state_reg == ST_DUMMY) && fall && (cnt_reg != lat) |=> (state_reg == ST_DUMMY))
    else $error("Dummy phase ended early");

endmodule : sfar_core

`default_nettype wire

// ### verification/sfar_host_model.sv
// Host controller model that frames reads on the serial flash link.
`timescale 1ns/10ps
`default_nettype none

module sfar_host_model (
  // Link pins
  output logic            spi_sck,
  output logic            spi_cs_n,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe_n,
  // Received bytes and drive faults
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  output logic      [7:0] oe_bad
);
  logic [3:0] h_val;
  logic [3:0] h_en;
  logic [3:0] filler;

  // Wire level; a released line toggles so a stale value can never pass.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_in[i] = !io_oe_n[i] ? io_out[i] : h_en[i] ? h_val[i] : filler[i];
    end
  end

  // Idle link: clock low, not selected.
  initial begin
    spi_sck  = 1'b0;
    spi_cs_n = 1'b1;
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    oe_bad   = 8'h00;
    h_val    = 4'h0;
    h_en     = 4'h0;
    filler   = 4'h5;
  end

  // One clock: drive after the fall, sample late in the high half.
  task automatic cyc(input logic [3:0] v, input logic [3:0] en, input bit rd,
                     output logic [3:0] s);
    spi_sck = 1'b0;
    h_val   = v;
    h_en    = en;
    filler  = ~filler;
    #80 spi_sck = 1'b1;
    #70 s = io_in;
    if (!rd && io_oe_n !== 4'hf) oe_bad = oe_bad + 8'h01;
    #10;
  endtask : cyc

  // A whole frame; the caller picks each phase.
  task automatic frame(input bit c_on, input logic [7:0] c, input int ab, input bit a2,
                       input logic [31:0] a, input bit m_on, input logic [7:0] m,
                       input int dum, input int dl, input int nb);
    logic [3:0] s;
    logic [7:0] b;
    spi_cs_n = 1'b0;
    #20;
    for (int k = 7; k >= 0; k--) if (c_on) cyc({3'b000, c[k]}, 4'h1, 1'b0, s);
    for (int k = ab - 1; k >= 0; k -= (a2 ? 2 : 1)) begin
      if (a2) cyc({2'b00, a[k], a[k-1]}, 4'h3, 1'b0, s);
      else cyc({3'b000, a[k]}, 4'h1, 1'b0, s);
    end
    // Low nibble of the mode left floating to free the lines early.
    for (int k = 7; k > 0; k -= 2) if (m_on) cyc({2'b00, m[k], m[k-1]}, (k > 3) ? 4'h3 : 4'h0, 1'b0, s);
    repeat (dum) cyc(4'h0, 4'h0, 1'b0, s);
    repeat (nb) begin
      b = 8'h00;
      repeat (8 / dl) begin
        cyc(4'h0, 4'h0, 1'b1, s);
        if (dl == 1) b = {b[6:0], s[1]};
        else if (dl == 2) b = {b[5:0], s[1:0]};
        else b = {b[3:0], s};
      end
      rx_byte  = b;
      rx_valid = 1'b1;
      #1 rx_valid = 1'b0;
    end
    #70 spi_sck = 1'b0;
    #80 spi_cs_n = 1'b1;
    h_en = 4'h0;
    #200;
    if (io_oe_n !== 4'hf) oe_bad = oe_bad + 8'h01;
  endtask : frame
endmodule : sfar_host_model
`default_nettype wire

// ### verification/serial_flash_array_read_tb.sv
// Self-checking bench for the serial flash array read front end.
`timescale 1ns/10ps
`default_nettype none
`include "sfar_params.svh"

module serial_flash_array_read_tb;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        spi_sck;
  logic        spi_cs_n;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe_n;
  logic        addr_wide = 1'b0;
  logic [3:0]  lat_two = 4'h0;
  logic [3:0]  lat_three = 4'h0;
  logic        execute_in_place;
  logic [23:0] arr_addr;
  logic        arr_rd;
  logic [7:0]  arr_rdata = 8'h00;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic [7:0]  oe_bad;
  logic [7:0]  exp_q[$];
  int          n_errors = 0;
  int          check_count = 0;

  always #10 ref_clk = ~ref_clk;

  sfar_core DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .volatile_config_two_addr_wide(addr_wide), .volatile_config_two_latency(lat_two),
    .volatile_config_three_latency(lat_three), .execute_in_place_active(execute_in_place),
    .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_rdata(arr_rdata)
  );

  sfar_host_model host (
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n), .rx_valid(rx_valid), .rx_byte(rx_byte), .oe_bad(oe_bad)
  );

  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h96;
  endfunction : mem

  // Array: byte valid the cycle after the strobe, scrambled otherwise.
  always @(posedge ref_clk) arr_rdata <= #1 (arr_rd ? mem(arr_addr) : ~arr_rdata);

  task automatic err(input string m);
    n_errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : err

  task automatic chk(input logic got, input logic want, input string m);
    check_count++;
    if (got !== want) err(m);
  endtask : chk

  // Each received byte is matched against the oldest noted one.
  always @(posedge rx_valid) begin
    check_count++;
    if (exp_q.size() == 0) err("byte with nothing expected");
    else begin
      if (rx_byte !== exp_q[0]) err($sformatf("got %h want %h", rx_byte, exp_q[0]));
      void'(exp_q.pop_front());
    end
  end

  // Notes the expected bytes, then runs the frame on the link.
  task automatic rd(input bit c_on, input logic [7:0] c, input int ab, input bit a2,
                    input logic [31:0] a, input bit m_on, input logic [7:0] m,
                    input int dum, input int dl, input int nb);
    for (int i = 0; i < nb; i++) exp_q.push_back(mem(a[23:0] + 24'(i)));
    @(posedge ref_clk);
    #1 host.frame(c_on, c, ab, a2, a, m_on, m, dum, dl, nb);
  endtask : rd

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    logic [7:0] cmds[8] = '{`SFAR_CMD_PLAIN, `SFAR_CMD_PLAIN_WIDE, `SFAR_CMD_FAST,
      `SFAR_CMD_FAST_WIDE, `SFAR_CMD_TWO_OUT, `SFAR_CMD_TWO_OUT_WIDE,
      `SFAR_CMD_FOUR_OUT, `SFAR_CMD_FOUR_OUT_W};
    int r;
    int ab;
    int dl;
    int dm;
    r = $urandom(36);
    repeat (12) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      #1 addr_wide = 1'($urandom);
      lat_two   = 4'($urandom_range(3));
      lat_three = 4'($urandom_range(3));
      ab = (i[0] || addr_wide) ? 32 : 24;
      dl = (i < 4) ? 1 : (i < 6) ? 2 : 4;
      dm = (i < 2) ? 0 : (i < 4) ? int'(lat_two) : int'(lat_three);
      rd(1'b1, cmds[i], ab, 1'b0, $urandom, 1'b0, 8'h00, dm, dl, 3);
      $display("test read %h done", cmds[i]);
    end
    @(posedge ref_clk);
    #1 addr_wide = 1'b0;
    lat_two = 4'h2;
    rd(1'b1, `SFAR_CMD_PLAIN, 24, 1'b0, 32'h00fffffe, 1'b0, 8'h00, 0, 1, 4);
    $display("test wrap done");
    rd(1'b1, `SFAR_CMD_TWO_IO, 24, 1'b1, $urandom, 1'b1, 8'ha5, 2, 2, 2);
    chk(execute_in_place, 1'b1, "continuous mode not entered");
    rd(1'b0, 8'h00, 24, 1'b1, $urandom, 1'b1, 8'h5a, 2, 2, 2);
    chk(execute_in_place, 1'b0, "continuous mode not left");
    rd(1'b1, `SFAR_CMD_PLAIN, 24, 1'b0, $urandom, 1'b0, 8'h00, 0, 1, 2);
    rd(1'b1, `SFAR_CMD_TWO_IO_WIDE, 32, 1'b1, $urandom, 1'b1, 8'haf, 2, 2, 2);
    rd(1'b0, 8'h00, 32, 1'b1, $urandom, 1'b1, 8'ha0, 2, 2, 2);
    chk(execute_in_place, 1'b1, "continuous mode lost");
    rd(1'b0, 8'h00, 16, 1'b1, 32'hffffffff, 1'b0, 8'h00, 0, 2, 0);
    chk(execute_in_place, 1'b0, "mode reset ignored");
    rd(1'b1, `SFAR_CMD_FAST, 24, 1'b0, $urandom, 1'b0, 8'h00, 2, 1, 2);
    // An unknown instruction must leave every line released for the whole frame.
    rd(1'b1, 8'h5a, 24, 1'b0, $urandom, 1'b0, 8'h00, 0, 1, 0);
    $display("test continuous read done");
    check_count++;
    if (oe_bad !== 8'h00) err("outputs driven outside data");
    if (exp_q.size() != 0) err("bytes missing");
    test_done();
  end

  // Watchdog well beyond the expected run of about 0.13 ms.
  initial begin
    #1000000;
    err("watchdog expired");
    test_done();
  end
endmodule : serial_flash_array_read_tb
`default_nettype wire
